// *** common/adx_pkg.sv ***
// constants for the converter-to-data-ram dma sequencer
package adx_pkg;
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_CFG = 8'h00;
   localparam logic [7:0] OFF_INSTR_PORT = 8'h04;
   localparam logic [7:0] OFF_BOUNDARY = 8'h08;
   localparam logic [7:0] OFF_IPTR_STATUS = 8'h0C;
   localparam logic [7:0] OFF_START_ADDR = 8'h10;
   localparam logic [7:0] OFF_WPTR = 8'h14;
   localparam logic [7:0] OFF_REPEAT_LIMIT = 8'h18;
   localparam logic [7:0] OFF_REPEAT_CNT = 8'h1C;
   localparam logic [7:0] OFF_STATUS = 8'h20;
   // configuration field positions
   localparam int CFG_ENABLE = 0;
   localparam int CFG_HALT = 1;
   // status field positions
   localparam int ST_BUSY = 0;
   localparam int ST_EXT_BUSY = 1;
   localparam int ST_OVERFLOW = 2;
   localparam int ST_RUNNING = 3;
   // instruction fields
   localparam int INS_CONTINUOUS_CONVERSION_BIT = 7;
   localparam int INS_DIFF = 6;
   localparam int INS_SECOND = 5;
   localparam int INS_FIRST = 4;
   // reset values
   localparam logic [15:0] RST_ADDR = 16'h0000;
   localparam logic [7:0] RST_BYTE = 8'h00;
   // state codes
   typedef enum logic [5:0] {
      ST_IDLE = 6'b00_0001,
      ST_FETCH = 6'b00_0010,
      ST_WAIT = 6'b00_0100,
      ST_WRITE = 6'b00_1000,
      ST_EOP = 6'b01_0000,
      ST_DONE = 6'b10_0000
   } adx_state_e;
endpackage

// *** hdl/adx_dma.sv ***
// converter-to-data-ram dma sequencer with wishbone registers
//
// Overview of operation
// (R1) zero word or bit7-only word ends operation
// (R2) first, second, or both converter results written
// (R3) differential result, optionally then second converter
// (R4) each data instruction stores two or four bytes
// (R5) software loads only defined instruction encodings
// (R6) unrequested converter stays under processor control
// (R7) on-chip writes only when core is idle
// (R8) halt bit selects off-chip ram owner
// (R9) software checks busy before setting halt
// (R10) core off-chip access dropped while halt clear
// (R11) pending off-chip write waits for halt clear
// (R12) new data before write flags overflow
// (R13) write pointer loaded from start address
// (R14) write pointer advances by bytes stored
// (R15) operation start loads pointer from boundary
// (R16) fetch, wait for data, execute, increment; the pointer increments when data is ready, before the write
// (R17) end-of-operation resets pointer to boundary
// (R18) continuous bit ignores repeat counter
// (R19) otherwise decrement counter, stop at zero
// (R20) operation start loads repeat counter from limit
// (R21) high byte at lower address, always
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps
module adx_dma #(
   parameter int IBUF_DEPTH = 64,
   parameter logic [15:0] ONCHIP_SIZE = 16'h1000
)(
   // system
   input wire logic clk,
   input wire logic rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // converters
   input wire logic first_converter_done,
   input wire logic [15:0] first_converter_result,
   input wire logic second_converter_done,
   input wire logic [15:0] second_converter_result,
   output logic first_converter_claimed,
   output logic second_converter_claimed,
   // data ram port
   input wire logic core_onchip_access,
   output logic ram_we,
   output logic ram_offchip,
   output logic [15:0] ram_addr,
   output logic [7:0] ram_wdata,
   // processor off-chip gate
   input wire logic core_offchip_req,
   output logic core_offchip_grant
);
   localparam int AW = $clog2(IBUF_DEPTH);

   if (IBUF_DEPTH < 2 || IBUF_DEPTH > 256 || (IBUF_DEPTH & (IBUF_DEPTH - 1)) != 0)
   begin : g_depth_check
      $error("IBUF_DEPTH must be a power of two in 2..256");
   end

   // ****************************************
   // registers
   // ****************************************
   logic [7:0] ibuf [IBUF_DEPTH];
   logic enable_ff;
   logic halt_ff;
   logic [7:0] boundary_ff;
   logic [7:0] iptr_ff;
   logic [15:0] start_addr_ff;
   logic [15:0] wptr_ff;
   logic [15:0] limit_ff;
   logic [15:0] rcnt_ff;
   logic overflow_ff;
   logic ack_ff;
   logic [31:0] rdata_ff;
   adx_pkg::adx_state_e state_ff;
   logic [7:0] instr_ff;
   logic [1:0] byte_idx_ff;
   logic [1:0] byte_cnt_ff;
   logic [15:0] word0_ff;
   logic [15:0] word1_ff;
   logic got_first_ff;
   logic got_second_ff;
   logic enable_d_ff;

   logic wb_req;
   logic wb_wr;
   logic start_op;
   logic need_first;
   logic need_second;
   logic data_ready;
   logic is_offchip;
   logic can_write;
   logic [7:0] fetched;
   logic last_byte;

   function automatic logic [1:0] byte_pairs(input logic [7:0] ins);
      // count of two-byte words the instruction stores
      byte_pairs = (ins[adx_pkg::INS_SECOND] && (ins[adx_pkg::INS_FIRST] || ins[adx_pkg::INS_DIFF]))
         ? 2'd2 : 2'd1;
   endfunction

   function automatic logic is_eop(input logic [7:0] ins);
      is_eop = (ins[6:0] == 7'h00); // R1
   endfunction

   function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] din, input logic [1:0] sel);
      lane_merge = {sel[1] ? din[15:8] : old[15:8], sel[0] ? din[7:0] : old[7:0]};
   endfunction

   assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdata_ff;
   assign start_op = enable_ff && !enable_d_ff;
   assign fetched = ibuf[iptr_ff[AW-1:0]];

   // differential claims only the first converter and uses the first result path
   assign need_first = instr_ff[adx_pkg::INS_FIRST] || instr_ff[adx_pkg::INS_DIFF]; // R3
   assign need_second = instr_ff[adx_pkg::INS_SECOND]; // R2 R3
   assign data_ready = (!need_first || got_first_ff) && (!need_second || got_second_ff);
   assign is_offchip = (ram_addr >= ONCHIP_SIZE);
   assign last_byte = (byte_idx_ff == {byte_cnt_ff[1], 1'b1}); // R4
   assign can_write = is_offchip ? !halt_ff : !core_onchip_access; // R7 R8 R11

   // converters not in the program stay with the processor
   assign first_converter_claimed = (state_ff == adx_pkg::ST_WAIT) && need_first; // R6
   assign second_converter_claimed = (state_ff == adx_pkg::ST_WAIT) && need_second; // R6

   assign ram_we = (state_ff == adx_pkg::ST_WRITE) && can_write;
   assign ram_offchip = is_offchip;
   assign ram_addr = wptr_ff + {14'h0000, byte_idx_ff};
   // high byte first at the lower address
   assign ram_wdata = byte_idx_ff[1]
      ? (byte_idx_ff[0] ? word1_ff[7:0] : word1_ff[15:8])
      : (byte_idx_ff[0] ? word0_ff[7:0] : word0_ff[15:8]); // R21
   assign core_offchip_grant = core_offchip_req && halt_ff; // R8 R10

   // ****************************************
   // bus slave
   // ****************************************
   always_ff @(posedge clk)
   begin
      ack_ff <= !rst && wb_req;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rdata_ff <= 32'h0000_0000;
      end
      else if (wb_req)
      begin
         case (wb_adr_i)
            adx_pkg::OFF_CFG: rdata_ff <= {30'h0000_0000, halt_ff, enable_ff};
            adx_pkg::OFF_BOUNDARY: rdata_ff <= {24'h00_0000, boundary_ff};
            adx_pkg::OFF_IPTR_STATUS: rdata_ff <= {24'h00_0000, iptr_ff};
            adx_pkg::OFF_START_ADDR: rdata_ff <= {16'h0000, start_addr_ff};
            adx_pkg::OFF_WPTR: rdata_ff <= {16'h0000, wptr_ff};
            adx_pkg::OFF_REPEAT_LIMIT: rdata_ff <= {16'h0000, limit_ff};
            adx_pkg::OFF_REPEAT_CNT: rdata_ff <= {16'h0000, rcnt_ff};
            adx_pkg::OFF_STATUS: rdata_ff <= {28'h000_0000,
               (state_ff != adx_pkg::ST_IDLE && state_ff != adx_pkg::ST_DONE), overflow_ff,
               (state_ff == adx_pkg::ST_WRITE) && is_offchip, (state_ff != adx_pkg::ST_IDLE)};
            default: rdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         enable_ff <= 1'b0;
         halt_ff <= 1'b0;
         enable_d_ff <= 1'b0;
      end
      else
      begin
         enable_d_ff <= enable_ff;
         if (wb_wr && wb_adr_i == adx_pkg::OFF_CFG)
         begin
            enable_ff <= wb_dat_i[adx_pkg::CFG_ENABLE];
            halt_ff <= wb_dat_i[adx_pkg::CFG_HALT];
         end
      end
   end

   // byte lanes of 16-bit registers: lane 0 low byte, lane 1 high byte
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         boundary_ff <= adx_pkg::RST_BYTE;
         start_addr_ff <= adx_pkg::RST_ADDR;
         limit_ff <= adx_pkg::RST_ADDR;
      end
      else if (wb_req && wb_we_i)
      begin
         if (wb_adr_i == adx_pkg::OFF_BOUNDARY && wb_sel_i[0])
         begin
            boundary_ff <= wb_dat_i[7:0];
         end
         if (wb_adr_i == adx_pkg::OFF_START_ADDR)
         begin
            start_addr_ff <= lane_merge(start_addr_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
         end
         if (wb_adr_i == adx_pkg::OFF_REPEAT_LIMIT)
         begin
            limit_ff <= lane_merge(limit_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
         end
      end
   end

   // instruction buffer fill at the pointer, pointer steps after each write
   always_ff @(posedge clk)
   begin
      if (wb_wr && wb_adr_i == adx_pkg::OFF_INSTR_PORT && state_ff == adx_pkg::ST_IDLE)
      begin
         ibuf[iptr_ff[AW-1:0]] <= wb_dat_i[7:0];
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_ff <= adx_pkg::ST_IDLE;
         instr_ff <= adx_pkg::RST_BYTE;
         byte_idx_ff <= 2'd0;
         byte_cnt_ff <= 2'd0;
      end
      else if (!enable_ff)
      begin
         state_ff <= adx_pkg::ST_IDLE;
      end
      else
      begin
         case (state_ff)
            adx_pkg::ST_IDLE:
            begin
               state_ff <= start_op ? adx_pkg::ST_FETCH : adx_pkg::ST_IDLE;
            end
            adx_pkg::ST_FETCH:
            begin
               instr_ff <= fetched; // R16
               state_ff <= is_eop(fetched) ? adx_pkg::ST_EOP : adx_pkg::ST_WAIT; // R1
            end
            adx_pkg::ST_WAIT:
            begin
               if (data_ready) // R16
               begin
                  byte_idx_ff <= 2'd0;
                  byte_cnt_ff <= byte_pairs(instr_ff); // R4
                  state_ff <= adx_pkg::ST_WRITE;
               end
            end
            adx_pkg::ST_WRITE:
            begin
               if (can_write)
               begin
                  byte_idx_ff <= byte_idx_ff + 2'd1;
                  if (last_byte) // R4
                  begin
                     state_ff <= adx_pkg::ST_FETCH;
                  end
               end
            end
            adx_pkg::ST_EOP:
            begin
               state_ff <= (instr_ff[adx_pkg::INS_CONTINUOUS_CONVERSION_BIT] || rcnt_ff > 16'h0001) // R18 R19
                  ? adx_pkg::ST_FETCH : adx_pkg::ST_DONE;
            end
            adx_pkg::ST_DONE:
            begin
               state_ff <= adx_pkg::ST_DONE;
            end
            default:
            begin
               state_ff <= adx_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // instruction pointer
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         iptr_ff <= adx_pkg::RST_BYTE;
      end
      else if (wb_wr && wb_adr_i == adx_pkg::OFF_IPTR_STATUS)
      begin
         iptr_ff <= wb_dat_i[7:0];
      end
      else if (wb_wr && wb_adr_i == adx_pkg::OFF_INSTR_PORT && state_ff == adx_pkg::ST_IDLE)
      begin
         iptr_ff <= iptr_ff + 8'd1;
      end
      else if (start_op || state_ff == adx_pkg::ST_EOP)
      begin
         iptr_ff <= boundary_ff; // R15 R17
      end
      else if (state_ff == adx_pkg::ST_WAIT && data_ready)
      begin
         iptr_ff <= iptr_ff + 8'd1; // R16
      end
   end

   // write pointer and repeat counter
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wptr_ff <= adx_pkg::RST_ADDR;
         rcnt_ff <= adx_pkg::RST_ADDR;
      end
      else if (start_op)
      begin
         wptr_ff <= start_addr_ff; // R13
         rcnt_ff <= limit_ff; // R20
      end
      else
      begin
         if (state_ff == adx_pkg::ST_WRITE && can_write && last_byte)
         begin
            wptr_ff <= wptr_ff + {13'h0000, byte_cnt_ff, 1'b0}; // R14
         end
         if (state_ff == adx_pkg::ST_EOP && !instr_ff[adx_pkg::INS_CONTINUOUS_CONVERSION_BIT] && rcnt_ff != 16'h0000)
         begin
            rcnt_ff <= rcnt_ff - 16'h0001; // R19
         end
      end
   end

   // converter capture and overflow
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         got_first_ff <= 1'b0;
         got_second_ff <= 1'b0;
         word0_ff <= adx_pkg::RST_ADDR;
         word1_ff <= adx_pkg::RST_ADDR;
      end
      else if (state_ff == adx_pkg::ST_FETCH)
      begin
         got_first_ff <= 1'b0;
         got_second_ff <= 1'b0;
      end
      else if (state_ff == adx_pkg::ST_WAIT)
      begin
         if (need_first && first_converter_done && !got_first_ff)
         begin
            got_first_ff <= 1'b1;
            word0_ff <= first_converter_result; // R2 R3
         end
         if (need_second && second_converter_done && !got_second_ff)
         begin
            got_second_ff <= 1'b1;
            word1_ff <= second_converter_result; // R2 R3
            if (!need_first)
            begin
               word0_ff <= second_converter_result; // R2
            end
         end
      end
   end

   // sticky overflow; set wins over a clear by write-one
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         overflow_ff <= 1'b0;
      end
      else if (state_ff == adx_pkg::ST_WRITE
         && ((need_first && first_converter_done) || (need_second && second_converter_done)))
      begin
         overflow_ff <= 1'b1; // R12
      end
      else if (wb_wr && wb_adr_i == adx_pkg::OFF_STATUS && wb_dat_i[adx_pkg::ST_OVERFLOW])
      begin
         overflow_ff <= 1'b0;
      end
   end
endmodule

// *** verification/adx_dma_props.sv ***
// port assertions for the dma sequencer
`timescale 1ns/100ps
module adx_dma_chk #(
   parameter logic [15:0] ONCHIP_SIZE = 16'h1000
)(
   // system
   input wire logic clk,
   input wire logic rst,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   // engine
   input wire logic first_converter_claimed,
   input wire logic second_converter_claimed,
   input wire logic core_onchip_access,
   input wire logic ram_we,
   input wire logic ram_offchip,
   input wire logic [15:0] ram_addr,
   input wire logic core_offchip_req,
   input wire logic core_offchip_grant
);
   // ************************
   // halt shadow and properties
   // ************************
   logic taken;
   logic halt_ff;
   assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
   always_ff @(posedge clk)
   begin
      if (rst)
         halt_ff <= 1'b0;
      else if (taken && wb_we_i && wb_adr_i == adx_pkg::OFF_CFG && wb_sel_i[0])
         halt_ff <= wb_dat_i[adx_pkg::CFG_HALT];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_ack_answer; taken |=> wb_ack_o; endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("no ack one cycle after request");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_idle; !wb_ack_o && !taken |=> !wb_ack_o; endproperty
   a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
   property p_onchip_free; ram_we && !ram_offchip |-> !core_onchip_access; endproperty
   a_onchip_free: assert property (p_onchip_free) else $error("on-chip write while core busy");
   property p_offchip_halt; ram_we && ram_offchip |-> !halt_ff; endproperty
   a_offchip_halt: assert property (p_offchip_halt) else $error("off-chip write while halted");
   property p_grant; core_offchip_grant == (core_offchip_req && halt_ff); endproperty
   a_grant: assert property (p_grant) else $error("off-chip grant wrong");
   property p_region; ram_we |-> ram_offchip == (ram_addr >= ONCHIP_SIZE); endproperty
   a_region: assert property (p_region) else $error("off-chip flag wrong");
   property p_no_claim; ram_we |-> !first_converter_claimed && !second_converter_claimed; endproperty
   a_no_claim: assert property (p_no_claim) else $error("write while still waiting");
endmodule

bind adx_dma adx_dma_chk #(.ONCHIP_SIZE(ONCHIP_SIZE)) u_chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .first_converter_claimed(first_converter_claimed),
   .second_converter_claimed(second_converter_claimed), .core_onchip_access(core_onchip_access),
   .ram_we(ram_we), .ram_offchip(ram_offchip), .ram_addr(ram_addr), .core_offchip_req(core_offchip_req),
   .core_offchip_grant(core_offchip_grant));

// *** verification/adx_far_model.sv ***
// converter pair and data ram stand-in
`timescale 1ns/100ps
module adx_far_model (
   // system
   input wire logic clk,
   // converters
   input wire logic slow,
   input wire logic burst,
   input wire logic [1:0] claimed,
   output logic [1:0] done,
   // data ram
   input wire logic ram_we,
   input wire logic [15:0] ram_addr,
   input wire logic [7:0] ram_wdata
);
   // ************************
   // conversion timing and ram
   // ************************
   logic [7:0] mem [0:65535];
   logic [3:0] cnt_ff [2];
   always_ff @(posedge clk)
   begin
      for (int c = 0; c < 2; c++)
      begin
         done[c] <= burst || (claimed[c] && cnt_ff[c] == (slow ? 4'h9 : 4'h1));
         cnt_ff[c] <= (claimed[c] && !done[c]) ? cnt_ff[c] + 4'h1 : 4'h0;
      end
      if (ram_we)
         mem[ram_addr] <= ram_wdata;
   end
endmodule

// *** verification/tb_top.sv ***
// self-checking bench for the dma sequencer
`timescale 1ns/100ps
module tb_top;
   // ************************
   // stimulus and checks
   // ************************
   localparam logic [15:0] V1 = 16'ha55a;
   localparam logic [15:0] V2 = 16'h3cc3;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic core_on = 1'b0;
   logic creq = 1'b0;
   logic slow = 1'b0;
   logic burst = 1'b0;
   logic [31:0] rdat, q;
   logic ack, rwe, roff, cgnt;
   logic [1:0] done, clm;
   logic [15:0] raddr, a;
   logic [7:0] rwd;
   int n_fail = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [15:0] rows [9] = '{16'h0000, 16'h1020, 16'h2021, 16'h3040, 16'h4020, 16'h5020, 16'h6040,
      16'h9020, 16'he040};
   initial
   begin
      forever #20 clk = ~clk;
   end
   adx_dma u_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .first_converter_done(done[0]),
      .first_converter_result(V1), .second_converter_done(done[1]), .second_converter_result(V2),
      .first_converter_claimed(clm[0]), .second_converter_claimed(clm[1]), .core_onchip_access(core_on),
      .ram_we(rwe), .ram_offchip(roff), .ram_addr(raddr), .ram_wdata(rwd), .core_offchip_req(creq),
      .core_offchip_grant(cgnt));
   adx_far_model u_ram (.clk(clk), .slow(slow), .burst(burst), .claimed(clm), .done(done), .ram_we(rwe),
      .ram_addr(raddr), .ram_wdata(rwd));
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         conclude();
      end
   end
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      do
         @(posedge clk);
      while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      bus(1'b1, ad, d);
   endtask
   task automatic rd(input logic [7:0] ad);
      bus(1'b0, ad, 32'h0000_0000);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic prog(input logic [7:0] b, i0, i1, input logic [15:0] st, lim, input logic [1:0] cf);
      wr(adx_pkg::OFF_BOUNDARY, {24'h00_0000, b});
      wr(adx_pkg::OFF_IPTR_STATUS, {24'h00_0000, b});
      wr(adx_pkg::OFF_INSTR_PORT, {24'h00_0000, i0});
      wr(adx_pkg::OFF_INSTR_PORT, {24'h00_0000, i1});
      wr(adx_pkg::OFF_START_ADDR, {16'h0000, st});
      wr(adx_pkg::OFF_REPEAT_LIMIT, {16'h0000, lim});
      wr(adx_pkg::OFF_CFG, {30'h0000_0000, cf});
   endtask
   task automatic fin;
      do
         rd(adx_pkg::OFF_STATUS);
      while (q[adx_pkg::ST_RUNNING] !== 1'b0);
      wr(adx_pkg::OFF_CFG, 32'h0000_0000);
   endtask
   task automatic chk_wptr(input logic [15:0] e);
      rd(adx_pkg::OFF_WPTR);
      chk("write pointer", {16'h0000, e}, q);
   endtask
   function automatic logic [7:0] exp_byte(input int k, input logic sec);
      logic [15:0] w;
      w = (k < 2 && !sec) ? V1 : V2;
      return k[0] ? w[7:0] : w[15:8];
   endfunction
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(adx_pkg::OFF_STATUS);
      chk("status", 32'h0000_0000, q);
      rd(8'h30);
      chk("unmapped", 32'h0000_0000, q);
      chk_wptr(adx_pkg::RST_ADDR);
      $display("reset test done");
      for (int i = 0; i < 9; i++)
      begin
         a = 16'h0100 + 16'(i * 16);
         prog(8'h00, rows[i][15:8], 8'h00, a, 16'h0001, 2'b01);
         fin();
         for (int k = 0; k < int'(rows[i][7:4]); k++)
            chk("ram byte", {24'h00_0000, exp_byte(k, rows[i][0])}, {24'h00_0000, u_ram.mem[a + 16'(k)]});
         chk_wptr(a + 16'(rows[i][7:4]));
         $display("row %0d done", i);
      end
      slow <= 1'b1;
      prog(8'h04, 8'h30, 8'h00, 16'h0600, 16'h0003, 2'b01);
      rd(adx_pkg::OFF_REPEAT_CNT);
      chk("repeat counter", 32'h0000_0003, q);
      fin();
      chk_wptr(16'h060c);
      rd(adx_pkg::OFF_REPEAT_CNT);
      chk("repeat counter", 32'h0000_0000, q);
      rd(adx_pkg::OFF_IPTR_STATUS);
      chk("instruction pointer", 32'h0000_0004, q);
      $display("repeat test done");
      slow <= 1'b0;
      prog(8'h00, 8'h10, 8'h80, 16'h0400, 16'h0001, 2'b01);
      do
         rd(adx_pkg::OFF_WPTR);
      while (q[15:0] < 16'h0406);
      rd(adx_pkg::OFF_STATUS);
      chk("still active", 32'h0000_0001, {31'h0000_0000, q[adx_pkg::ST_RUNNING]});
      wr(adx_pkg::OFF_CFG, 32'h0000_0000);
      $display("continuous test done");
      rd(adx_pkg::OFF_STATUS);
      chk("ext busy", 32'h0000_0000, {31'h0000_0000, q[adx_pkg::ST_EXT_BUSY]});
      wr(adx_pkg::OFF_CFG, 32'h0000_0002);
      prog(8'h00, 8'h10, 8'h00, 16'h2000, 16'h0001, 2'b11);
      repeat (20) @(posedge clk);
      chk_wptr(16'h2000);
      creq <= 1'b1;
      @(posedge clk);
      chk("grant", 32'h0000_0001, {31'h0000_0000, cgnt});
      wr(adx_pkg::OFF_CFG, 32'h0000_0001);
      chk("grant", 32'h0000_0000, {31'h0000_0000, cgnt});
      fin();
      creq <= 1'b0;
      chk("ram byte", {24'h00_0000, V1[15:8]}, {24'h00_0000, u_ram.mem[16'h2000]});
      $display("off-chip test done");
      core_on <= 1'b1;
      prog(8'h00, 8'h10, 8'h00, 16'h0800, 16'h0001, 2'b01);
      repeat (10) @(posedge clk);
      chk("second claim", 32'h0000_0000, {31'h0000_0000, clm[1]});
      burst <= 1'b1;
      @(posedge clk);
      burst <= 1'b0;
      chk_wptr(16'h0800);
      rd(adx_pkg::OFF_STATUS);
      chk("overflow", 32'h0000_0001, {31'h0000_0000, q[adx_pkg::ST_OVERFLOW]});
      core_on <= 1'b0;
      fin();
      wr(adx_pkg::OFF_STATUS, 32'h0000_0004);
      rd(adx_pkg::OFF_STATUS);
      chk("overflow", 32'h0000_0000, {31'h0000_0000, q[adx_pkg::ST_OVERFLOW]});
      chk_wptr(16'h0802);
      $display("overflow test done");
      prog(8'h00, 8'h10, 8'h80, 16'h0300, 16'h0001, 2'b01);
      repeat (30) @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(adx_pkg::OFF_STATUS);
      chk("status", 32'h0000_0000, q);
      chk_wptr(adx_pkg::RST_ADDR);
      rd(adx_pkg::OFF_CFG);
      chk("config", 32'h0000_0000, q);
      rd(adx_pkg::OFF_REPEAT_CNT);
      chk("repeat counter", 32'h0000_0000, q);
      $display("mid-run reset test done");
      conclude();
   end
endmodule
